//--- verilog/usm_pkg.sv
// Shared constants, state types and frame helpers for the serial transceiver
package usm_pkg;
    // Character format codes
    localparam logic [1:0] FMT_EIGHT = 2'h0;
    localparam logic [1:0] FMT_SEVEN = 2'h1;
    localparam logic [1:0] FMT_NINE = 2'h2;
    localparam logic [1:0] FMT_LOOP = 2'h3;
    // Parity kinds
    localparam logic [1:0] PAR_ODD = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_MARK = 2'h2;
    localparam logic [1:0] PAR_SPACE = 2'h3;
    // Oversampling: sixteen ticks per bit, three samples after eight waits
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam logic [3:0] OS_SAMPLE_FIRST = 4'h8;
    localparam logic [3:0] OS_SAMPLE_LAST = 4'hA;
    // Prescaler, frame width and data bit counts
    localparam logic [4:0] PSC_OFF = 5'h00;
    localparam logic [5:0] PSC_HALF_STEP = 6'h02;
    localparam int FRAME_W = 12;
    localparam logic [3:0] NINE_BITS = 4'h9;
    localparam logic [3:0] EIGHT_BITS = 4'h8;
    localparam logic [3:0] SEVEN_BITS = 4'h7;

    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} usm_tx_state_type;
    typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BUSY = 2'b10} usm_rx_state_type;

    // Data bits per character
    function automatic logic [3:0] data_bits(input logic [1:0] fmt);
        return (fmt == FMT_EIGHT) ? EIGHT_BITS : (fmt == FMT_SEVEN) ? SEVEN_BITS : NINE_BITS; // RL23
    endfunction : data_bits

    // Parity only with seven and eight data bits
    function automatic logic has_parity(input logic [1:0] fmt, input logic pen);
        return pen && (fmt == FMT_EIGHT || fmt == FMT_SEVEN); // RL17 RL18
    endfunction : has_parity

    // Whole frame length: start, data, parity, stop bits
    function automatic logic [3:0] frame_len(input logic [1:0] fmt, input logic pen, input logic two_stop);
        return 4'h2 + data_bits(fmt) + {3'h0, has_parity(fmt, pen)} + {3'h0, two_stop};
    endfunction : frame_len

    // Frame image, sent from bit 0 upward, idle ones above
    function automatic logic [FRAME_W-1:0] frame_build(input logic [7:0] data, input logic ninth,
                                                       input logic [1:0] fmt, input logic pen,
                                                       input logic [1:0] psel);
        logic [FRAME_W-1:0] f;
        logic [8:0] word;
        logic [3:0] nd;
        logic even;
        f = '1;
        word = {ninth, data}; // RL13
        nd = data_bits(fmt);
        even = (fmt == FMT_SEVEN) ? ^data[6:0] : ^data;
        f[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(nd)) begin
                f[i+1] = word[i]; // RL4
            end
        end
        if (has_parity(fmt, pen)) begin
            f[nd+4'h1] = (psel == PAR_ODD) ? ~even : (psel == PAR_EVEN) ? even : (psel == PAR_MARK); // RL17
        end
        return f;
    endfunction : frame_build

    // Right-align received data bits that entered at the top
    function automatic logic [8:0] align_word(input logic [8:0] sh, input logic [3:0] nd);
        return (nd == NINE_BITS) ? sh : (nd == EIGHT_BITS) ? {1'b0, sh[8:1]} : {2'h0, sh[8:2]};
    endfunction : align_word

    // Two of three vote
    function automatic logic vote(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : vote
endpackage : usm_pkg

//--- verilog/usm_link_if.sv
// Serial link between the transceiver and the remote party
`timescale 1ns/10ps
`default_nettype none
interface usm_link_if;
    logic dev_txd;
    logic rem_txd;
    logic dev_sck_out;
    logic dev_sck_oe;
    logic rem_sck_out;
    logic rem_sck_oe;
    logic sck_level;
    // Resolved clock wire, pulled low when nobody drives
    assign sck_level = dev_sck_oe ? dev_sck_out : (rem_sck_oe ? rem_sck_out : 1'b0);
    modport device (output dev_txd, output dev_sck_out, output dev_sck_oe, input rem_txd, input sck_level);
    modport remote (output rem_txd, output rem_sck_out, output rem_sck_oe, input dev_txd, input sck_level);
endinterface : usm_link_if
`default_nettype wire

//--- verilog/usm_baud.sv
// Two-stage baud generator: half-step prescaler and eleven-bit divisor
`timescale 1ns/10ps
`default_nettype none
module usm_baud import usm_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [4:0] prescale_select,
    input wire logic [10:0] rate_divisor,
    output logic tick
);
    logic [5:0] half_acc_q;
    logic [10:0] div_cnt_q;
    logic tick_q;

    // Prescaler counts in half cycles; factor is (code+1)/2
    wire run = prescale_select != PSC_OFF; // RL20
    wire [5:0] thresh = {1'b0, prescale_select} + 6'h01; // RL19
    wire [5:0] acc_next = half_acc_q + PSC_HALF_STEP;
    wire pre_tick = acc_next >= thresh;
    wire div_wrap = div_cnt_q >= rate_divisor; // RL24

    // Second stage divides by divisor plus one
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            half_acc_q <= 6'h00;
            div_cnt_q <= 11'h000;
            tick_q <= 1'b0;
        end else if (!run) begin
            half_acc_q <= 6'h00; // RL20
            div_cnt_q <= 11'h000;
            tick_q <= 1'b0;
        end else begin
            half_acc_q <= pre_tick ? acc_next - thresh : acc_next; // RL19
            tick_q <= pre_tick && div_wrap; // RL21
            if (pre_tick) begin
                div_cnt_q <= div_wrap ? 11'h000 : div_cnt_q + 11'h001; // RL24
            end
        end
    end

    assign tick = tick_q;
endmodule : usm_baud
`default_nettype wire

//--- verilog/usm_device.sv
// Transceiver end: double-buffered transmit and receive, async and sync modes
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [RL1] Frame end loads shifter, sets empty flag
// [RL2] Holding write clears empty flag
// [RL3] Busy flag until frame done and empty
// [RL4] Bits shift least significant first
// [RL5] Async uses baud ticks, sixteen per bit
// [RL6] Start bit: wait eight, three lows
// [RL7] Later bits: two-of-three mid-bit vote
// [RL8] Full character copies to holding, sets full
// [RL9] Holding read clears full flag
// [RL10] Sync: send on rise, capture on fall
// [RL11] Sync: character ends after frame rising edges
// [RL12] Sync clock external, or internal driven out
// [RL13] Nine-bit characters, ninth bit marks address
// [RL14] Address wait discards data, address clears it
// [RL15] Software re-arms or leaves address wait; only re-arm here, no clear input
// [RL16] Loopback feeds transmit into receive, nine-bit
// [RL17] Parity appended for seven/eight bit frames
// [RL18] Nine-bit: ninth bit separate, no parity
// [RL19] Prescaler half steps, then eleven-bit divisor
// [RL20] Prescaler zero stops the clock
// [RL21] Async rate is clock/16/N/P
// [RL22] Software stops clock before rate change
// [RL23] Format field selects eight/seven/nine/loopback
// [RL24] Divisor used is field plus one
module usm_device import usm_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    usm_link_if.device link,
    input wire logic [7:0] tx_data,
    input wire logic tx_ninth_bit,
    input wire logic tx_write,
    input wire logic rx_read,
    input wire logic address_wait_set,
    input wire logic [1:0] char_format_field,
    input wire logic parity_enable_bit,
    input wire logic [1:0] parity_select,
    input wire logic two_stop_bits,
    input wire logic sync_mode,
    input wire logic internal_clock,
    input wire logic [4:0] prescale_select,
    input wire logic [10:0] rate_divisor,
    output logic [7:0] rx_holding_buffer,
    output logic rx_ninth_bit,
    output logic tx_empty_flag,
    output logic tx_in_progress_flag,
    output logic rx_full_flag,
    output logic address_wait_bit
);
    logic tick;
    logic [2:0] rxd_sync_q;
    logic [2:0] sck_sync_q;
    logic rxd_f_q;
    logic sck_f_q;
    usm_tx_state_type tx_state_q;
    usm_rx_state_type rx_state_q;
    logic [FRAME_W-1:0] tx_shifter_q;
    logic [7:0] tx_holding_buffer_q;
    logic [3:0] tx_idx_q;
    logic [3:0] tx_sub_q;
    logic txd_q;
    logic sck_q;
    logic sck_oe_q;
    logic tx_empty_q;
    logic tx_in_progress_q;
    logic [8:0] rx_shifter_q;
    logic [3:0] rx_idx_q;
    logic [3:0] rx_sub_q;
    logic [3:0] rx_rise_q;
    logic [2:0] rx_samples_q;
    logic [7:0] rx_holding_q;
    logic rx_ninth_q;
    logic rx_full_q;
    logic address_wait_q;

    usm_baud u_baud (
        .clk(clk),
        .reset_n(reset_n),
        .prescale_select(prescale_select),
        .rate_divisor(rate_divisor),
        .tick(tick)
    );

    // Three-stage pin synchronisers, change taken once stages two and three agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxd_sync_q <= 3'h7;
            sck_sync_q <= 3'h0;
            rxd_f_q <= 1'b1;
            sck_f_q <= 1'b0;
        end else begin
            rxd_sync_q <= {rxd_sync_q[1:0], link.rem_txd};
            sck_sync_q <= {sck_sync_q[1:0], link.sck_level};
            if (rxd_sync_q[1] == rxd_sync_q[2]) begin
                rxd_f_q <= rxd_sync_q[2];
            end
            if (sck_sync_q[1] == sck_sync_q[2]) begin
                sck_f_q <= sck_sync_q[2];
            end
        end
    end

    // Frame shape and clock edges
    wire [3:0] nd = data_bits(char_format_field); // RL23
    wire [3:0] flen = frame_len(char_format_field, parity_enable_bit, two_stop_bits);
    wire [3:0] async_last = flen - 4'h1 - {3'h0, two_stop_bits};
    wire loopback = char_format_field == FMT_LOOP;
    wire rx_line = loopback ? txd_q : rxd_f_q; // RL16
    wire sck_agree = sck_sync_q[1] == sck_sync_q[2];
    wire ext_rise = sck_agree && sck_sync_q[2] && !sck_f_q;
    wire ext_fall = sck_agree && !sck_sync_q[2] && sck_f_q;
    wire int_run = sync_mode && internal_clock && tick && tx_state_q == TX_SHIFT;
    wire sck_rise = internal_clock ? (int_run && !sck_q) : ext_rise; // RL12
    wire sck_fall = internal_clock ? (int_run && sck_q) : ext_fall; // RL12

    // Transmit sequencing
    wire tx_busy = tx_state_q == TX_SHIFT;
    wire tx_adv = sync_mode ? sck_rise : (tick && tx_sub_q == OS_LAST); // RL5 RL10
    wire tx_done = tx_busy && tx_idx_q == flen && (sync_mode ? sck_fall : tx_adv);
    wire tx_load = (!tx_busy || tx_done) && !tx_empty_q; // RL1
    wire tx_empty_d = tx_load ? 1'b1 : (tx_write ? 1'b0 : tx_empty_q); // RL1 RL2
    wire tx_busy_d = tx_load || (tx_busy && !tx_done);

    // Transmit shifter and serial output
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state_q <= TX_IDLE;
            tx_shifter_q <= '1;
            tx_idx_q <= 4'h0;
            tx_sub_q <= 4'h0;
            txd_q <= 1'b1;
        end else if (tx_load) begin
            tx_shifter_q <= frame_build(tx_holding_buffer_q, tx_ninth_bit, char_format_field,
                                        parity_enable_bit, parity_select); // RL1 RL17 RL18
            tx_state_q <= TX_SHIFT;
            tx_sub_q <= 4'h0;
            tx_idx_q <= sync_mode ? 4'h0 : 4'h1;
            txd_q <= sync_mode ? txd_q : 1'b0;
        end else if (tx_done) begin
            tx_state_q <= TX_IDLE;
            txd_q <= 1'b1;
        end else if (tx_busy) begin
            if (tick && !sync_mode) begin
                tx_sub_q <= tx_sub_q + 4'h1; // RL5
            end
            if (tx_adv && tx_idx_q != flen) begin
                txd_q <= tx_shifter_q[tx_idx_q]; // RL4 RL10
                tx_idx_q <= tx_idx_q + 4'h1;
            end
        end
    end

    // Holding buffer, empty and in-progress flags, internal clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_holding_buffer_q <= 8'h00;
            tx_empty_q <= 1'b1;
            tx_in_progress_q <= 1'b0;
            sck_q <= 1'b0;
            sck_oe_q <= 1'b0;
        end else begin
            if (tx_write) begin
                tx_holding_buffer_q <= tx_data;
            end
            tx_empty_q <= tx_empty_d; // RL2
            tx_in_progress_q <= tx_busy_d || !tx_empty_d; // RL3
            sck_oe_q <= sync_mode && internal_clock; // RL12
            if (!(sync_mode && internal_clock)) begin
                sck_q <= 1'b0;
            end else if (int_run) begin
                sck_q <= !sck_q; // RL12
            end
        end
    end

    // Receive bit events
    wire rx_async_start = !sync_mode && rx_state_q == RX_IDLE && tick && !rx_line;
    wire rx_async_evt = !sync_mode && rx_state_q == RX_BUSY && tick && rx_sub_q == OS_LAST;
    wire rx_evt = sync_mode ? sck_fall : rx_async_evt; // RL10
    wire rx_bit = sync_mode ? rx_line : vote(rx_samples_q); // RL7
    wire rx_bad_start = rx_async_evt && rx_idx_q == 4'h0 && rx_samples_q != 3'h0; // RL6
    wire rx_sample = rx_state_q == RX_BUSY && tick && rx_sub_q >= OS_SAMPLE_FIRST && rx_sub_q <= OS_SAMPLE_LAST;
    wire rx_complete = rx_evt && (sync_mode ? rx_rise_q == flen : rx_idx_q == async_last); // RL11
    wire [8:0] rx_word = align_word(rx_shifter_q, nd);
    wire rx_is_nine = nd == NINE_BITS;
    wire rx_accept = !(address_wait_q && rx_is_nine && !rx_word[8]); // RL13 RL14

    // Receive shifter and oversampling
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state_q <= RX_IDLE;
            rx_shifter_q <= 9'h000;
            rx_idx_q <= 4'h0;
            rx_sub_q <= 4'h0;
            rx_rise_q <= 4'h0;
            rx_samples_q <= 3'h7;
        end else begin
            if (rx_async_start) begin
                rx_state_q <= RX_BUSY;
                rx_sub_q <= 4'h0;
                rx_idx_q <= 4'h0;
            end else if (rx_state_q == RX_BUSY && tick) begin
                rx_sub_q <= rx_sub_q + 4'h1; // RL5
            end
            if (rx_sample) begin
                rx_samples_q <= {rx_line, rx_samples_q[2:1]}; // RL6 RL7
            end
            if (sync_mode && sck_rise) begin
                rx_rise_q <= rx_rise_q + 4'h1; // RL11
            end
            if (rx_evt && rx_idx_q >= 4'h1 && rx_idx_q <= nd) begin
                rx_shifter_q <= {rx_bit, rx_shifter_q[8:1]}; // RL4
            end
            if (rx_bad_start || rx_complete) begin
                rx_state_q <= RX_IDLE; // RL6
                rx_idx_q <= 4'h0;
                rx_rise_q <= 4'h0;
            end else if (rx_evt) begin
                rx_idx_q <= rx_idx_q + 4'h1;
            end
        end
    end

    // Holding buffer, full flag and address wait
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_holding_q <= 8'h00;
            rx_ninth_q <= 1'b0;
            rx_full_q <= 1'b0;
            address_wait_q <= 1'b0;
        end else begin
            if (rx_complete && rx_accept) begin
                rx_holding_q <= rx_word[7:0]; // RL8
                rx_ninth_q <= rx_is_nine && rx_word[8]; // RL18
                rx_full_q <= 1'b1; // RL8
            end else if (rx_read) begin
                rx_full_q <= 1'b0; // RL9
            end
            if (address_wait_set) begin
                address_wait_q <= 1'b1;
            end else if (rx_complete && rx_accept) begin
                address_wait_q <= 1'b0; // RL14
            end
        end
    end

    // Outputs
    assign link.dev_txd = txd_q;
    assign link.dev_sck_out = sck_q;
    assign link.dev_sck_oe = sck_oe_q;
    assign rx_holding_buffer = rx_holding_q;
    assign rx_ninth_bit = rx_ninth_q;
    assign tx_empty_flag = tx_empty_q;
    assign tx_in_progress_flag = tx_in_progress_q;
    assign rx_full_flag = rx_full_q;
    assign address_wait_bit = address_wait_q;
endmodule : usm_device
`default_nettype wire

//--- verilog/usm_remote.sv
// Remote party: simple transceiver on the far end of the serial link
`timescale 1ns/10ps
`default_nettype none
module usm_remote import usm_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    usm_link_if.remote link,
    input wire logic [1:0] char_format_field,
    input wire logic two_stop_bits,
    input wire logic sync_mode,
    input wire logic drive_clock,
    input wire logic [15:0] bit_cycles,
    input wire logic [8:0] send_word,
    input wire logic send_valid,
    output logic send_ready,
    output logic [8:0] recv_word,
    output logic recv_valid
);
    logic [2:0] rxd_sync_q;
    logic [2:0] sck_sync_q;
    logic rxd_f_q;
    logic sck_f_q;
    usm_tx_state_type tx_state_q;
    usm_rx_state_type rx_state_q;
    logic [FRAME_W-1:0] tx_frame_q;
    logic [3:0] tx_idx_q;
    logic [15:0] tcnt_q;
    logic [15:0] rcnt_q;
    logic txd_q;
    logic sck_q;
    logic ready_q;
    logic [8:0] rsh_q;
    logic [3:0] ridx_q;
    logic [3:0] rrise_q;
    logic [8:0] word_q;
    logic valid_q;

    // Pin synchronisers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxd_sync_q <= 3'h7;
            sck_sync_q <= 3'h0;
            rxd_f_q <= 1'b1;
            sck_f_q <= 1'b0;
        end else begin
            rxd_sync_q <= {rxd_sync_q[1:0], link.dev_txd};
            sck_sync_q <= {sck_sync_q[1:0], link.sck_level};
            if (rxd_sync_q[1] == rxd_sync_q[2]) begin
                rxd_f_q <= rxd_sync_q[2];
            end
            if (sck_sync_q[1] == sck_sync_q[2]) begin
                sck_f_q <= sck_sync_q[2];
            end
        end
    end

    // Timing and edges
    wire [3:0] nd = data_bits(char_format_field);
    wire [3:0] flen = frame_len(char_format_field, 1'b0, two_stop_bits);
    wire [15:0] half = {1'b0, bit_cycles[15:1]};
    wire tx_busy = tx_state_q == TX_SHIFT;
    wire own_tick = tx_busy && sync_mode && drive_clock && tcnt_q == half - 16'h0001;
    wire agree = sck_sync_q[1] == sck_sync_q[2];
    wire rise = drive_clock ? (own_tick && !sck_q) : (agree && sck_sync_q[2] && !sck_f_q); // RL12
    wire fall = drive_clock ? (own_tick && sck_q) : (agree && !sck_sync_q[2] && sck_f_q); // RL12
    wire async_adv = !sync_mode && tcnt_q == bit_cycles - 16'h0001;
    wire tx_adv = sync_mode ? rise : async_adv; // RL10
    wire tx_done = tx_busy && tx_idx_q == flen && (sync_mode ? fall : async_adv);
    wire tx_load = send_valid && ready_q;

    // Transmitter with optional clock drive
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state_q <= TX_IDLE;
            tx_frame_q <= '1;
            tx_idx_q <= 4'h0;
            tcnt_q <= 16'h0000;
            txd_q <= 1'b1;
            sck_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            ready_q <= !tx_load && (!tx_busy || tx_done);
            if (own_tick) begin
                sck_q <= !sck_q; // RL10
            end
            if (tx_load) begin
                tx_frame_q <= frame_build(send_word[7:0], send_word[8], char_format_field, 1'b0, PAR_ODD); // RL13
                tx_state_q <= TX_SHIFT;
                tcnt_q <= 16'h0000;
                tx_idx_q <= sync_mode ? 4'h0 : 4'h1;
                txd_q <= sync_mode ? txd_q : 1'b0;
            end else if (tx_done) begin
                tx_state_q <= TX_IDLE;
                txd_q <= 1'b1;
            end else if (tx_busy) begin
                tcnt_q <= (async_adv || own_tick) ? 16'h0000 : tcnt_q + 16'h0001;
                if (tx_adv && tx_idx_q != flen) begin
                    txd_q <= tx_frame_q[tx_idx_q]; // RL4
                    tx_idx_q <= tx_idx_q + 4'h1;
                end
            end
        end
    end

    // Receiver: async mid-bit sampling or sync capture on falling edges
    wire r_start = !sync_mode && rx_state_q == RX_IDLE && !rxd_f_q;
    wire r_async = !sync_mode && rx_state_q == RX_BUSY
                   && rcnt_q == ((ridx_q == 4'h0) ? half : bit_cycles) - 16'h0001;
    wire r_evt = sync_mode ? fall : r_async; // RL10
    wire r_false = r_async && ridx_q == 4'h0 && rxd_f_q;
    wire r_done = r_evt && (sync_mode ? rrise_q == flen : ridx_q == nd + 4'h1); // RL11

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state_q <= RX_IDLE;
            rsh_q <= 9'h000;
            ridx_q <= 4'h0;
            rrise_q <= 4'h0;
            rcnt_q <= 16'h0000;
            word_q <= 9'h000;
            valid_q <= 1'b0;
        end else begin
            valid_q <= r_done;
            rcnt_q <= (r_start || r_async) ? 16'h0000 : rcnt_q + 16'h0001;
            if (r_start) begin
                rx_state_q <= RX_BUSY;
            end
            if (sync_mode && rise) begin
                rrise_q <= rrise_q + 4'h1;
            end
            if (r_evt && ridx_q >= 4'h1 && ridx_q <= nd) begin
                rsh_q <= {rxd_f_q, rsh_q[8:1]};
            end
            if (r_done) begin
                word_q <= align_word(rsh_q, nd); // RL13
            end
            if (r_false || r_done) begin
                rx_state_q <= RX_IDLE;
                ridx_q <= 4'h0;
                rrise_q <= 4'h0;
            end else if (r_evt) begin
                ridx_q <= ridx_q + 4'h1;
            end
        end
    end

    assign link.rem_txd = txd_q;
    assign link.rem_sck_out = sck_q;
    assign link.rem_sck_oe = sync_mode && drive_clock;
    assign send_ready = ready_q;
    assign recv_word = word_q;
    assign recv_valid = valid_q;
endmodule : usm_remote
`default_nettype wire

//--- sim/usm_sva.sv
// Checker for the serial link and the transceiver flags
`timescale 1ns/10ps
`default_nettype none
module usm_sva (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic dev_txd,
    input wire logic dev_sck_oe,
    input wire logic sck_level,
    input wire logic sync_mode,
    input wire logic tx_write,
    input wire logic rx_read,
    input wire logic tx_empty_flag,
    input wire logic tx_in_progress_flag,
    input wire logic rx_full_flag,
    input wire logic address_wait_bit
);
    // Single clock domain, all checks idle during reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Transmit flags
    a_write_clears_empty: assert property (tx_write && tx_empty_flag |=> !tx_empty_flag) else $error("empty kept");
    a_empty_holds: assert property (tx_empty_flag && !tx_write |=> tx_empty_flag) else $error("empty lost");
    a_busy_ends_empty: assert property ($fell(tx_in_progress_flag) |-> tx_empty_flag) else $error("busy drop");
    a_busy_from_write: assert property ($rose(tx_in_progress_flag) |-> $past(tx_write)) else $error("busy rise");
    // Receive flags
    a_read_clears_full: assert property (rx_read && rx_full_flag |=> !rx_full_flag) else $error("full kept");
    a_full_holds: assert property (rx_full_flag && !rx_read |=> rx_full_flag) else $error("full lost");
    a_wait_ends_full: assert property ($fell(address_wait_bit) |-> ##[0:1] rx_full_flag) else $error("wait drop");
    // Link clock
    a_fall_data_stable: assert property (sync_mode && $fell(sck_level) |-> $stable(dev_txd)) else $error("data moved");
    a_async_no_clock: assert property (!sync_mode && !$past(sync_mode) |-> !dev_sck_oe) else $error("clock on");
    // Main scenarios reached
    c_address: cover property ($fell(address_wait_bit));
    c_sync_fall: cover property (sync_mode && $fell(sck_level));
    c_frame_end: cover property ($fell(tx_in_progress_flag));
endmodule : usm_sva
`default_nettype wire

//--- sim/usm_tb.sv
// Bench: transceiver and remote end joined across the serial link
`timescale 1ns/10ps
`default_nettype none
module usm_tb;
    import usm_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, tx_ninth_bit = 1'b0, tx_write = 1'b0, rx_read = 1'b0;
    logic address_wait_set = 1'b0, two_stop_bits = 1'b0, sync_mode = 1'b0, internal_clock = 1'b0;
    logic drive_clock = 1'b0, send_valid = 1'b0, pe = 1'b0, rx_ninth_bit, tx_empty_flag, tx_in_progress_flag;
    logic rx_full_flag, address_wait_bit, send_ready, recv_valid;
    logic [7:0] tx_data = 8'h00, rx_holding_buffer;
    logic [1:0] char_format_field = FMT_EIGHT;
    logic [8:0] send_word = 9'h000, recv_word;
    int err_count = 0, cmp_count = 0, cyc = 0;
    usm_link_if link();
    usm_device usm_device_inst (.clk, .reset_n, .link, .tx_data, .tx_ninth_bit, .tx_write, .rx_read, .address_wait_set,
        .char_format_field, .parity_enable_bit(pe), .parity_select(PAR_ODD), .two_stop_bits, .sync_mode,
        .internal_clock, .prescale_select(5'h01), .rate_divisor(11'h007), .rx_holding_buffer, .rx_ninth_bit,
        .tx_empty_flag, .tx_in_progress_flag, .rx_full_flag, .address_wait_bit);
    usm_remote usm_remote_inst (.clk, .reset_n, .link, .char_format_field(char_format_field ^ {1'b0, pe}),
        .two_stop_bits, .sync_mode, .drive_clock, .bit_cycles(16'h0080), .send_word, .send_valid, .send_ready,
        .recv_word, .recv_valid);
    usm_sva usm_sva_inst (.clk, .reset_n, .dev_txd(link.dev_txd), .dev_sck_oe(link.dev_sck_oe),
        .sck_level(link.sck_level), .sync_mode, .tx_write, .rx_read, .tx_empty_flag, .tx_in_progress_flag,
        .rx_full_flag, .address_wait_bit);
    // Clock and hang limit
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            wrap_up();
        end
    end
    // Compare and verdict
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    // Access tasks on both user sides
    task automatic dev_write(input logic [7:0] d, input logic n);
        tx_data <= d;
        tx_ninth_bit <= n;
        tx_write <= 1'b1;
        @(posedge clk);
        tx_write <= 1'b0;
        @(negedge clk);
    endtask : dev_write
    task automatic wait_lvl(ref logic f, input logic v);
        do @(negedge clk); while (f !== v);
        @(posedge clk);
    endtask : wait_lvl
    task automatic wait_recv(input logic [8:0] exp);
        do @(negedge clk); while (recv_valid !== 1'b1);
        check(recv_word, exp);
        @(posedge clk);
    endtask : wait_recv
    task automatic wait_full(input logic [8:0] exp);
        wait_lvl(rx_full_flag, 1'b1);
        check({rx_ninth_bit, rx_holding_buffer}, exp);
        rx_read <= 1'b1;
        @(posedge clk);
        rx_read <= 1'b0;
        @(negedge clk);
        check(rx_full_flag, 9'h000);
        @(posedge clk);
    endtask : wait_full
    task automatic rem_send(input logic [8:0] w);
        send_word <= w;
        send_valid <= 1'b1;
        do @(posedge clk); while (send_ready !== 1'b1);
        send_valid <= 1'b0;
        @(posedge clk);
    endtask : rem_send
    // Test sequence
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        check(tx_empty_flag, 9'h001);
        dev_write(8'hA5, 1'b0);
        check({tx_empty_flag, tx_in_progress_flag}, 9'h001);
        wait_lvl(tx_empty_flag, 1'b1);
        dev_write(8'h3C, 1'b0);
        wait_recv(9'h0A5);
        wait_recv(9'h03C);
        {pe, char_format_field} <= {1'b1, FMT_SEVEN};
        dev_write(8'h35, 1'b0);
        wait_recv(9'h0B5);
        wait_lvl(tx_in_progress_flag, 1'b0);
        check(tx_empty_flag, 9'h001);
        $display("Test async transmit done");
        char_format_field <= FMT_LOOP;
        @(posedge clk);
        dev_write(8'h5A, 1'b1);
        wait_full(9'h15A);
        $display("Test loopback done");
        char_format_field <= FMT_NINE;
        address_wait_set <= 1'b1;
        @(posedge clk);
        address_wait_set <= 1'b0;
        rem_send(9'h033);
        rem_send(9'h1A7);
        repeat (300) @(posedge clk);
        check({rx_full_flag, address_wait_bit}, 9'h001);
        wait_full(9'h1A7);
        check(address_wait_bit, 9'h000);
        rem_send(9'h0C3);
        wait_full(9'h0C3);
        $display("Test address wait done");
        {pe, sync_mode, internal_clock, char_format_field, two_stop_bits} <= {3'h3, FMT_EIGHT, 1'b1};
        @(posedge clk);
        dev_write(8'h96, 1'b0);
        wait_recv(9'h096);
        wait_full(9'h0FF);
        $display("Test sync internal clock done");
        {internal_clock, drive_clock} <= 2'b01;
        @(posedge clk);
        rem_send(9'h069);
        wait_full(9'h069);
        $display("Test sync external clock done");
        wrap_up();
    end
endmodule : usm_tb
`default_nettype wire
